// [dcp_pkg.sv]
`default_nettype none
package dcp_pkg;
  typedef logic [31:0] dcp_word_t;
  typedef logic [7:0]  dcp_raddr_t;
  typedef logic [8:0]  dcp_cnt_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} dcp_state_e;

  // register byte offsets
  localparam dcp_raddr_t OFS_CTRL  = 8'h00;
  localparam dcp_raddr_t OFS_CHCON = 8'h10;
  localparam dcp_raddr_t OFS_EVCON = 8'h14;
  localparam dcp_raddr_t OFS_INT   = 8'h18;
  localparam dcp_raddr_t OFS_SSA   = 8'h20;
  localparam dcp_raddr_t OFS_DSA   = 8'h24;
  localparam dcp_raddr_t OFS_SSIZ  = 8'h28;
  localparam dcp_raddr_t OFS_DSIZ  = 8'h2C;
  localparam dcp_raddr_t OFS_SPTR  = 8'h30;
  localparam dcp_raddr_t OFS_DPTR  = 8'h34;
  localparam dcp_raddr_t OFS_CSIZ  = 8'h38;
  localparam dcp_raddr_t OFS_CPTR  = 8'h3C;
  localparam dcp_raddr_t OFS_PAT   = 8'h40;

  // field positions
  localparam int B_CTRL_ON   = 15;
  localparam int B_CTRL_SUSP = 12;
  localparam int B_CH_EN     = 7;
  localparam int B_CH_AUTO   = 4;
  localparam int B_EV_FORCE  = 7;
  localparam int B_EV_ABORT  = 6;
  localparam int B_EV_PAT    = 5;
  localparam int B_EV_SEN    = 4;
  localparam int B_EV_AEN    = 3;
  localparam int B_EV_SSEL   = 8;
  localparam int B_EV_ASEL   = 16;
  localparam int F_ERR   = 0;
  localparam int F_ABORT = 1;
  localparam int F_CELL  = 2;
  localparam int F_BLOCK = 3;
  localparam int F_DHALF = 4;
  localparam int F_DDONE = 5;
  localparam int F_SHALF = 6;
  localparam int F_SDONE = 7;

  // values after reset, word and full-block sizes
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam dcp_word_t  RST_WORD = 32'h0000_0000;
  localparam logic [2:0] WORD_BYTES = 3'h4;
  localparam dcp_cnt_t   FULL_SIZE  = 9'h100;

  // size field: zero means a full 256 bytes
  function automatic dcp_cnt_t dcp_size(input logic [7:0] v);
    return (v == 8'h00) ? FULL_SIZE : {1'b0, v};
  endfunction

  function automatic dcp_cnt_t dcp_min(input dcp_cnt_t a, input dcp_cnt_t b);
    return (a < b) ? a : b;
  endfunction
endpackage
`default_nettype wire

// [dcp_ptr_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface dcp_ptr_if;
  logic       clr;
  logic       adv;
  logic [2:0] amt;
  logic [8:0] size;
  logic [7:0] ptr;
  logic       half;
  logic       done;
  modport ctl  (output clr, adv, amt, size, input ptr, half, done);
  modport unit (input clr, adv, amt, size, output ptr, half, done);
endinterface
`default_nettype wire

// [dcp_ptr_unit.sv]
`timescale 1ns/100ps
`default_nettype none
module dcp_ptr_unit (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pointer control
  dcp_ptr_if.unit  p
);
  import dcp_pkg::*;

  dcp_cnt_t next_ptr;
  dcp_cnt_t half_pt;

  assign next_ptr = {1'b0, p.ptr} + {6'h00, p.amt};
  assign half_pt  = p.size >> 1;
  assign p.half   = p.adv && ({1'b0, p.ptr} < half_pt) && (next_ptr >= half_pt);
  assign p.done   = p.adv && (next_ptr >= p.size);

  always_ff @(posedge clk) begin
    if (reset || p.clr) begin
      p.ptr <= RST_BYTE;
    end else if (p.adv) begin
      p.ptr <= (next_ptr >= p.size) ? RST_BYTE : next_ptr[7:0];
    end
  end
endmodule // dcp_ptr_unit
`default_nettype wire

// [dcp_channel.sv]
// What this block does
// - moves data only with controller and channel enabled
// - force-start bit starts a cell transfer
// - matching enabled start event starts a transfer
// - each event moves one cell, then waits
// - transaction is one word read then write
// - pointers read-only, advance after each transaction
// - half and done flags per pointer
// - pointers cleared on reset, off, completion, abort
// - abort while suspended keeps all pointers
// - start address write clears its pointer
// - enable self-clears after block unless auto-enable
// - abort, pattern, abort event, error, completion stop
// - abort finishes current transaction, sets abort flag
// - block size is larger of both sizes
// - at most 256 bytes per block
// - pointers wrap at their programmed sizes
// - cell larger than block moves only block
// - written byte equal to pattern is match
// - match acts as block completion
// - pattern byte in low eight bits only
// - size value zero means 256 bytes
`timescale 1ns/100ps
`default_nettype none
module dcp_channel (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // register port
  input  wire dcp_pkg::dcp_raddr_t reg_addr,
  input  wire dcp_pkg::dcp_word_t  reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  dcp_pkg::dcp_word_t  reg_rdata,
  // system events
  input  wire logic              evt_valid,
  input  wire logic [7:0]        evt_num,
  // system bus master
  output var  dcp_pkg::dcp_word_t  bus_addr,
  output var  logic              bus_rd,
  output var  logic              bus_wr,
  output var  dcp_pkg::dcp_word_t  bus_wdata,
  output var  logic [3:0]        bus_be,
  input  wire dcp_pkg::dcp_word_t  bus_rdata,
  input  wire logic              bus_ack,
  input  wire logic              bus_err,
  // status
  output var  logic              chan_busy
);
  import dcp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  dcp_state_e  state;
  logic        ctl_on;
  logic        ctl_susp;
  logic        ch_en;
  logic        ch_auto;
  logic [7:0]  ev_ssel;
  logic [7:0]  ev_asel;
  logic        ev_pat;
  logic        ev_sen;
  logic        ev_aen;
  logic [7:0]  flags;
  dcp_word_t   ssa;
  dcp_word_t   dsa;
  logic [7:0]  ssiz;
  logic [7:0]  dsiz;
  logic [7:0]  csiz;
  logic [7:0]  pattern_byte;
  logic        cell_busy;
  logic        abort_pend;
  dcp_cnt_t    cptr;
  dcp_cnt_t    bcnt;
  logic [2:0]  xfer_n;
  logic [1:0]  soff;
  logic [1:0]  doff;
  dcp_word_t   daddr_q;
  logic        match_q;

  dcp_cnt_t    ssize;
  dcp_cnt_t    dsize;
  dcp_cnt_t    bsize;
  dcp_cnt_t    cell_len;
  dcp_cnt_t    rem;
  dcp_cnt_t    lane;
  dcp_cnt_t    next_n;
  dcp_word_t   sa;
  dcp_word_t   da;
  dcp_word_t   aligned;
  logic        rd_match;
  logic        stalled;
  logic        start_req;
  logic        abort_req;
  logic        go;
  logic        wr_done;
  logic        err_stop;
  logic        do_abort;
  logic        blk_done;
  logic        cell_done;
  logic        clr_ptrs;

  dcp_ptr_if src_if ();
  dcp_ptr_if dst_if ();

  function automatic logic reg_hit(input dcp_raddr_t ofs);
    return reg_wr && (reg_addr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // sizes and transaction length
  // zero means 256
  assign ssize = dcp_size(ssiz);
  assign dsize = dcp_size(dsiz);
  assign bsize = (ssize > dsize) ? ssize : dsize;
  assign cell_len = dcp_min(dcp_size(csiz), bsize);
  assign rem = dcp_min(dcp_min(cell_len - cptr, bsize - bcnt),
                       dcp_min(ssize - {1'b0, src_if.ptr}, dsize - {1'b0, dst_if.ptr}));
  assign sa = ssa + {24'h000000, src_if.ptr};
  assign da = dsa + {24'h000000, dst_if.ptr};
  // at most one word per transaction
  assign lane = dcp_min({7'h00, 2'h0 - sa[1:0]} + ((sa[1:0] == 2'h0) ? 9'h004 : 9'h000),
                        {7'h00, 2'h0 - da[1:0]} + ((da[1:0] == 2'h0) ? 9'h004 : 9'h000));
  assign next_n = dcp_min(rem, lane);

  ////////////////////////////////////////////////////////////////////////
  // triggers and stop causes
  // both enables needed
  assign stalled = !ctl_on || !ch_en || ctl_susp;
  assign start_req = ctl_on && ch_en &&
                     ((reg_hit(OFS_EVCON) && reg_wdata[B_EV_FORCE]) ||
                      (evt_valid && ev_sen && (evt_num == ev_ssel)));
  assign abort_req = (reg_hit(OFS_EVCON) && reg_wdata[B_EV_ABORT]) ||
                     (evt_valid && ev_aen && (evt_num == ev_asel));
  assign go = (state == ST_IDLE) && cell_busy && !stalled && !abort_pend && !abort_req;
  assign wr_done = (state == ST_WR) && bus_ack && !bus_err;
  assign err_stop = (state != ST_IDLE) && bus_err;
  assign do_abort = abort_pend && (state == ST_IDLE);
  assign blk_done = wr_done && ((bcnt + {6'h00, xfer_n} >= bsize) || match_q);
  assign cell_done = wr_done && (cptr + {6'h00, xfer_n} >= cell_len);
  assign clr_ptrs = !ctl_on || blk_done || (do_abort && !stalled);

  ////////////////////////////////////////////////////////////////////////
  // source and destination pointers
  // start address write clears
  assign src_if.clr  = clr_ptrs || reg_hit(OFS_SSA);
  assign dst_if.clr  = clr_ptrs || reg_hit(OFS_DSA);
  assign src_if.adv  = wr_done;
  assign dst_if.adv  = wr_done;
  assign src_if.amt  = xfer_n;
  assign dst_if.amt  = xfer_n;
  assign src_if.size = ssize;
  assign dst_if.size = dsize;

  dcp_ptr_unit u_src (
    .clk   (clk),
    .reset (reset),
    .p     (src_if.unit)
  );

  dcp_ptr_unit u_dst (
    .clk   (clk),
    .reset (reset),
    .p     (dst_if.unit)
  );

  always_ff @(posedge clk) begin
    if (reset || clr_ptrs || cell_done) begin
      cptr <= {1'b0, RST_BYTE};
    end else if (wr_done) begin
      cptr <= cptr + {6'h00, xfer_n};
    end
  end

  always_ff @(posedge clk) begin
    if (reset || clr_ptrs) begin
      bcnt <= {1'b0, RST_BYTE};
    end else if (wr_done) begin
      bcnt <= bcnt + {6'h00, xfer_n};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk) begin
    if (reset) begin
      ctl_on   <= 1'b0;
      ctl_susp <= 1'b0;
    end else if (reg_hit(OFS_CTRL)) begin
      ctl_on   <= reg_wdata[B_CTRL_ON];
      ctl_susp <= reg_wdata[B_CTRL_SUSP];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ch_en   <= 1'b0;
      ch_auto <= 1'b0;
    end else begin
      if (reg_hit(OFS_CHCON)) begin
        ch_en   <= reg_wdata[B_CH_EN];
        ch_auto <= reg_wdata[B_CH_AUTO];
      end
      if ((blk_done && !ch_auto) || err_stop || do_abort) begin
        ch_en <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ev_ssel <= RST_BYTE;
      ev_asel <= RST_BYTE;
      ev_pat  <= 1'b0;
      ev_sen  <= 1'b0;
      ev_aen  <= 1'b0;
    end else if (reg_hit(OFS_EVCON)) begin
      ev_ssel <= reg_wdata[B_EV_SSEL +: 8];
      ev_asel <= reg_wdata[B_EV_ASEL +: 8];
      ev_pat  <= reg_wdata[B_EV_PAT];
      ev_sen  <= reg_wdata[B_EV_SEN];
      ev_aen  <= reg_wdata[B_EV_AEN];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ssa          <= RST_WORD;
      dsa          <= RST_WORD;
      ssiz         <= RST_BYTE;
      dsiz         <= RST_BYTE;
      csiz         <= RST_BYTE;
      pattern_byte <= RST_BYTE;
    end else begin
      if (reg_hit(OFS_SSA)) ssa <= reg_wdata;
      if (reg_hit(OFS_DSA)) dsa <= reg_wdata;
      if (reg_hit(OFS_SSIZ)) ssiz <= reg_wdata[7:0];
      if (reg_hit(OFS_DSIZ)) dsiz <= reg_wdata[7:0];
      if (reg_hit(OFS_CSIZ)) csiz <= reg_wdata[7:0];
      if (reg_hit(OFS_PAT)) pattern_byte <= reg_wdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags: write one to clear, a set in the same cycle wins
  always_ff @(posedge clk) begin
    if (reset) begin
      flags <= RST_BYTE;
    end else begin
      if (reg_hit(OFS_INT)) flags <= flags & ~reg_wdata[7:0];
      if (err_stop) flags[F_ERR] <= 1'b1;
      if (do_abort) flags[F_ABORT] <= 1'b1;
      if (cell_done) flags[F_CELL] <= 1'b1;
      if (blk_done) flags[F_BLOCK] <= 1'b1;
      if (dst_if.half) flags[F_DHALF] <= 1'b1;
      if (dst_if.done) flags[F_DDONE] <= 1'b1;
      if (src_if.half) flags[F_SHALF] <= 1'b1;
      if (src_if.done) flags[F_SDONE] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pending cell and abort
  always_ff @(posedge clk) begin
    if (reset) begin
      cell_busy <= 1'b0;
    end else if (start_req) begin
      cell_busy <= 1'b1;
    end else if (cell_done || blk_done || do_abort || err_stop || !ctl_on) begin
      cell_busy <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      abort_pend <= 1'b0;
    end else if (abort_req) begin
      abort_pend <= 1'b1;
    end else if (do_abort || err_stop) begin
      abort_pend <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data realignment and pattern compare
  assign aligned = bus_rdata >> {soff, 3'h0};

  always_comb begin
    rd_match = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if ((i < int'(xfer_n)) && (aligned[8*i +: 8] == pattern_byte)) rd_match = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus transaction sequencer
  // read then write
  always_ff @(posedge clk) begin
    if (reset) begin
      state     <= ST_IDLE;
      bus_addr  <= RST_WORD;
      bus_rd    <= 1'b0;
      bus_wr    <= 1'b0;
      bus_wdata <= RST_WORD;
      bus_be    <= 4'h0;
      xfer_n    <= 3'h0;
      soff      <= 2'h0;
      doff      <= 2'h0;
      daddr_q   <= RST_WORD;
      match_q   <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (go) begin
            bus_addr <= {sa[31:2], 2'h0};
            bus_rd   <= 1'b1;
            bus_be   <= 4'hF;
            xfer_n   <= next_n[2:0];
            soff     <= sa[1:0];
            doff     <= da[1:0];
            daddr_q  <= da;
            state    <= ST_RD;
          end
        end
        ST_RD: begin
          if (bus_err) begin
            bus_rd <= 1'b0;
            bus_be <= 4'h0;
            state  <= ST_IDLE;
          end else if (bus_ack) begin
            bus_rd    <= 1'b0;
            bus_wr    <= 1'b1;
            bus_addr  <= {daddr_q[31:2], 2'h0};
            bus_wdata <= aligned << {doff, 3'h0};
            bus_be    <= 4'((5'h01 << xfer_n) - 5'h01) << doff;
            match_q   <= ev_pat && rd_match;
            state     <= ST_WR;
          end
        end
        ST_WR: begin
          if (bus_ack || bus_err) begin
            bus_wr  <= 1'b0;
            bus_be  <= 4'h0;
            match_q <= 1'b0;
            state   <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      chan_busy <= 1'b0;
    end else begin
      chan_busy <= cell_busy || (state != ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read port, data valid the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset || !reg_rd) begin
      reg_rdata <= RST_WORD;
    end else begin
      unique case (reg_addr)
        OFS_CTRL:  reg_rdata <= RST_WORD | (32'(ctl_on) << B_CTRL_ON) | (32'(ctl_susp) << B_CTRL_SUSP);
        OFS_CHCON: reg_rdata <= RST_WORD | (32'(ch_en) << B_CH_EN) | (32'(ch_auto) << B_CH_AUTO);
        OFS_EVCON: reg_rdata <= {8'h00, ev_asel, ev_ssel, 2'h0, ev_pat, ev_sen, ev_aen, 3'h0};
        OFS_INT:   reg_rdata <= {24'h000000, flags};
        OFS_SSA:   reg_rdata <= ssa;
        OFS_DSA:   reg_rdata <= dsa;
        OFS_SSIZ:  reg_rdata <= {24'h000000, ssiz};
        OFS_DSIZ:  reg_rdata <= {24'h000000, dsiz};
        OFS_SPTR:  reg_rdata <= {24'h000000, src_if.ptr};
        OFS_DPTR:  reg_rdata <= {24'h000000, dst_if.ptr};
        OFS_CSIZ:  reg_rdata <= {24'h000000, csiz};
        OFS_CPTR:  reg_rdata <= {24'h000000, cptr[7:0]};
        OFS_PAT:   reg_rdata <= {24'h000000, pattern_byte};
        default:   reg_rdata <= RST_WORD;
      endcase
    end
  end
endmodule // dcp_channel
`default_nettype wire

// [dcp_bus_mem.sv]
`timescale 1ns/100ps
`default_nettype none
module dcp_bus_mem (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // bus from the channel
  input  wire logic [31:0] bus_addr,
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic [3:0]  bus_be,
  output var  logic [31:0] bus_rdata,
  output var  logic        bus_ack,
  output var  logic        bus_err
);
  logic [7:0] mem [0:255];
  logic [1:0] wait_cnt;
  logic       slow;
  wire logic  req = (bus_rd || bus_wr) && !bus_ack && !bus_err;
  wire logic  hit = req && (wait_cnt == {slow, 1'b0});
  wire logic  bad = (bus_addr[31:28] == 4'hF);

  ////////////////////////////////////////////////////////////
  // answers alternate between prompt and two cycles late
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_ack  <= 1'b0;
      bus_err  <= 1'b0;
      wait_cnt <= 2'h0;
      slow     <= 1'b0;
    end else if (hit) begin
      // top region gives an address error
      bus_err  <= bad;
      bus_ack  <= !bad;
      wait_cnt <= 2'h0;
      slow     <= ~slow;
    end else begin
      bus_ack  <= 1'b0;
      bus_err  <= 1'b0;
      wait_cnt <= req ? wait_cnt + 2'h1 : 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////
  // whole word on every read
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_rdata <= 32'h0000_0000;
    end else if (hit && bus_rd) begin
      bus_rdata <= {{bus_addr[7:2], 2'h3}, {bus_addr[7:2], 2'h2}, {bus_addr[7:2], 2'h1},
                    {bus_addr[7:2], 2'h0}} ^ 32'h5A5A_5A5A;
    end else begin
      // outside an answer the read data inverts every cycle, so the old word returns every other cycle
      bus_rdata <= ~bus_rdata;
    end
  end

  always_ff @(posedge clk) begin
    for (int k = 0; k < 4; k++) begin
      if (hit && bus_wr && !bad && bus_be[k]) begin
        mem[{bus_addr[7:2], 2'(k)}] <= bus_wdata[8*k +: 8];
      end
    end
  end
endmodule // dcp_bus_mem
`default_nettype wire

// [dcp_channel_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module dcp_channel_chk (
  // clock and reset
  input wire logic               clk,
  input wire logic               reset,
  // register read side
  input wire logic               reg_rd,
  input wire dcp_pkg::dcp_word_t reg_rdata,
  // bus side
  input wire dcp_pkg::dcp_word_t bus_addr,
  input wire logic               bus_rd,
  input wire logic               bus_wr,
  input wire dcp_pkg::dcp_word_t bus_wdata,
  input wire logic [3:0]         bus_be,
  input wire logic               bus_ack,
  input wire logic               bus_err,
  input wire logic               chan_busy
);
  import dcp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_rd_ok;
    bus_rd && bus_ack && !bus_err;
  endsequence
  sequence s_wr_end;
    bus_wr && (bus_ack || bus_err);
  endsequence

  property p_excl;
    !(bus_rd && bus_wr);
  endproperty
  property p_rd_hold;
    bus_rd && !bus_ack && !bus_err |=> bus_rd && $stable(bus_addr);
  endproperty
  property p_wr_hold;
    bus_wr && !bus_ack && !bus_err |=> bus_wr && $stable(bus_wdata) && $stable(bus_be);
  endproperty
  property p_rd_wr;
    s_rd_ok |=> bus_wr && !bus_rd;
  endproperty
  property p_gap;
    s_wr_end |=> !bus_rd && !bus_wr;
  endproperty
  property p_be;
    bus_rd |-> bus_be == 4'hF;
  endproperty
  property p_idle_be;
    !bus_rd && !bus_wr |-> bus_be == 4'h0;
  endproperty
  property p_rdata;
    !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  property p_busy;
    bus_rd || bus_wr |-> chan_busy;
  endproperty
  property p_err_stop;
    bus_err && (bus_rd || bus_wr) |=> !bus_rd [*8];
  endproperty

  a_excl: assert property (p_excl) else $error("read and write requested together");
  a_rd_hold: assert property (p_rd_hold) else $error("read request dropped early");
  a_wr_hold: assert property (p_wr_hold) else $error("write request changed early");
  a_rd_wr: assert property (p_rd_wr) else $error("read not followed by write");
  a_gap: assert property (p_gap) else $error("no idle cycle after write");
  a_be: assert property (p_be) else $error("read not a full word");
  a_idle_be: assert property (p_idle_be) else $error("byte lanes active while idle");
  a_rdata: assert property (p_rdata) else $error("read data outside read slot");
  a_busy: assert property (p_busy) else $error("transaction without busy");
  a_err_stop: assert property (p_err_stop) else $error("channel kept reading after error");
endmodule // dcp_channel_chk

bind dcp_channel dcp_channel_chk u_chk (.clk(clk), .reset(reset), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_be(bus_be),
  .bus_ack(bus_ack), .bus_err(bus_err), .chan_busy(chan_busy));
`default_nettype wire

// [testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dcp_pkg::*;
  logic        clk, reset, reg_wr, reg_rd, evt_valid, bus_rd, bus_wr, bus_ack, bus_err, chan_busy;
  logic [7:0]  evt_num;
  logic [3:0]  bus_be;
  logic [31:0] seed;
  dcp_raddr_t  reg_addr;
  dcp_word_t   reg_wdata, reg_rdata, bus_addr, bus_wdata, bus_rdata, rv, ev;
  int          n_mismatch, checks_done, sp, dp, done, c, off, sel;

  dcp_channel u_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt_valid(evt_valid), .evt_num(evt_num),
    .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_be(bus_be),
    .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err), .chan_busy(chan_busy));
  dcp_bus_mem u_mem (.clk(clk), .reset(reset), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_wdata(bus_wdata), .bus_be(bus_be), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err));

  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // byte the far side holds at a source address
  function automatic dcp_word_t sb(input int a);
    return dcp_word_t'(a[7:0] ^ 8'h5A);
  endfunction
  task automatic wr(input dcp_raddr_t a, input dcp_word_t d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input dcp_raddr_t a, output dcp_word_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input dcp_word_t g, input dcp_word_t e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rchk(input dcp_raddr_t a, input dcp_word_t e);
    rd(a, rv);
    chk(rv, e);
  endtask
  task automatic pulse(input logic [7:0] n);
    @(posedge clk);
    evt_valid <= 1'b1;
    evt_num   <= n;
    @(posedge clk);
    evt_valid <= 1'b0;
  endtask
  task automatic fc(input dcp_word_t e);
    wr(OFS_EVCON, e | 32'h0000_0080);
  endtask
  task automatic idle();
    int n;
    n = 0;
    repeat (4) @(posedge clk);
    while (chan_busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic prog(input dcp_word_t sa, da, ss, ds, cs, e, ch);
    wr(OFS_INT, 32'h0000_00FF);
    wr(OFS_SSA, sa);
    wr(OFS_DSA, da);
    wr(OFS_SSIZ, ss);
    wr(OFS_DSIZ, ds);
    wr(OFS_CSIZ, cs);
    wr(OFS_EVCON, e);
    wr(OFS_CHCON, ch);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    {reset, reg_wr, reg_rd, evt_valid, evt_num, reg_addr, reg_wdata} = {4'h8, 8'h00, 8'h00, 32'h0};
    {seed, n_mismatch, checks_done} = {32'hFD88, 32'h0, 32'h0};
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    wr(OFS_SPTR, 32'h0000_0055);
    rchk(OFS_SPTR, 32'h0);
    rchk(8'h44, 32'h0);
    wr(OFS_PAT, 32'h0000_00A5);
    rchk(OFS_PAT, 32'h0000_00A5);
    $display("test registers done");
    sel = 1 + int'(xs() % 32'd200);
    ev = dcp_word_t'((sel << B_EV_SSEL) | (1 << B_EV_SEN));
    prog(32'h2000_0001, 32'h1000_0040, 32'h6, 32'hA, 32'h4, ev, 32'h80);
    fc(ev);
    idle();
    rchk(OFS_SPTR, 32'h0);
    rchk(OFS_INT, 32'h0);
    wr(OFS_CTRL, 32'h0000_8000);
    {sp, dp, done} = {32'h0, 32'h0, 32'h0};
    for (int k = 0; k < 3; k++) begin
      if (k == 1) begin
        pulse(8'(sel) ^ 8'h01);
        repeat (4) @(posedge clk);
        chk({31'h0, chan_busy}, 32'h0);
        pulse(8'(sel));
      end else begin
        fc(ev);
      end
      idle();
      c = (10 - done < 4) ? 10 - done : 4;
      done += c;
      sp = (done == 10) ? 0 : (sp + c) % 6;
      dp = (done == 10) ? 0 : (dp + c) % 10;
      rchk(OFS_SPTR, dcp_word_t'(sp));
      rchk(OFS_DPTR, dcp_word_t'(dp));
    end
    rd(OFS_INT, rv);
    chk(rv & 32'h28, 32'h28);
    rchk(OFS_CHCON, 32'h0);
    for (int i = 0; i < 10; i++) chk(dcp_word_t'(u_mem.mem[8'h40 + i]), sb(1 + i % 6));
    fc(ev);
    repeat (4) @(posedge clk);
    chk({31'h0, chan_busy}, 32'h0);
    $display("test basic block done");
    off = 1 + int'(xs() % 32'd6);
    wr(OFS_PAT, sb(16 + off));
    prog(32'h2000_0010, 32'h1000_0080, 32'h0, 32'h0, 32'h8, 32'h20, 32'h80);
    fc(32'h20);
    idle();
    rd(OFS_INT, rv);
    chk(rv & 32'h08, 32'h08);
    rchk(OFS_CHCON, 32'h0);
    rchk(OFS_SPTR, 32'h0);
    for (int i = 0; i <= off; i++) chk(dcp_word_t'(u_mem.mem[8'h80 + i]), sb(16 + i));
    $display("test pattern done");
    for (int m = 0; m < 2; m++) begin
      ev = m ? dcp_word_t'((8'h33 << B_EV_ASEL) | (1 << B_EV_AEN)) : 32'h0;
      prog(32'h2000_0000, 32'h1000_0000, 32'h0, 32'h0, 32'h0, ev, 32'h90);
      fc(ev);
      repeat (8) @(posedge clk);
      chk({31'h0, chan_busy}, 32'h1);
      if (m == 1) pulse(8'h33);
      else wr(OFS_EVCON, ev | 32'h40);
      idle();
      rd(OFS_INT, rv);
      chk(rv & 32'h02, 32'h02);
      rchk(OFS_CHCON, 32'h10);
      rchk(OFS_DPTR, 32'h0);
    end
    $display("test abort done");
    prog(32'hF000_0000, 32'h1000_0000, 32'h4, 32'h4, 32'h4, 32'h0, 32'h80);
    fc(32'h0);
    idle();
    rd(OFS_INT, rv);
    chk(rv & 32'h03, 32'h01);
    rchk(OFS_CHCON, 32'h0);
    $display("test address error done");
    prog(32'h2000_0000, 32'h1000_0000, 32'h8, 32'h8, 32'h4, 32'h0, 32'h80);
    fc(32'h0);
    idle();
    rchk(OFS_SPTR, 32'h4);
    wr(OFS_CTRL, 32'h0000_9000);
    wr(OFS_EVCON, 32'h40);
    rchk(OFS_SPTR, 32'h4);
    wr(OFS_CTRL, 32'h0);
    rchk(OFS_DPTR, 32'h0);
    $display("test suspend and off done");
    test_done();
  end
endmodule // testbench
`default_nettype wire
